/* File: status_summary_pkg.sv */
// Contract
// - Command 78h returns one read-only summary byte of critical faults.
// - Byte bit 6 is high whenever the converter is not enabled.
// - Byte bit 5 mirrors output-voltage status bit 7; zero on loop slave.
// - Byte bit 4 mirrors output-current status bit 7.
// - Summary bits ignore bus writes; they clear only when sources clear.
// - Byte bit 2 is high while any temperature fault or warning is set.
// - Byte bit 1 is high while any communication status bit is set.
// - Byte bit 0 is high for any other listed fault or warning.
// - Byte bit 0 reads one after reset since low-input flag resets high.
// - Command 79h returns two bytes; low byte equals the summary byte.
// - High bit 7 ORs all output-voltage faults, warnings and turn-on timeout.
// - High bit 6 ORs overcurrent fault and overcurrent warning.
// - High bit 5 is high while the low-input flag or any other input status bit is set.
// - High bit 4 is high for bandgap overtemperature or vendor fault source.
// - High bit 3 is live unlatched power-not-good from listed conditions.
// - Power-not-good alert mask defaults to one after reset.
// - Unmasked power-not-good alerts wait for first power-good after power-up.
// - Output-voltage status bits are host-cleared; the summaries keep no stored copy of them.
// - Low-input flag set at power-up, unlatched and silent until first turn-on.
package status_summary_pkg;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  // Output-voltage status bit positions
  localparam int VOUT_OV_FAULT_BIT = 7;
  localparam int VOUT_OV_WARN_BIT = 6;
  localparam int VOUT_UV_WARN_BIT = 5;
  localparam int VOUT_UV_FAULT_BIT = 4;
  localparam int VOUT_LIMIT_WARN_BIT = 3;
  localparam int VOUT_TON_TIMEOUT_BIT = 2;
  // Output-current status bit positions
  localparam int IOUT_OC_FAULT_BIT = 7;
  localparam int IOUT_OC_WARN_BIT = 5;
  // Input status low-input position
  localparam int INPUT_LOW_BIT = 3;
  // Temperature status bit positions
  localparam int TEMP_FAULT_BIT = 7;
  localparam int TEMP_WARN_BIT = 6;
  // Vendor status bit positions
  localparam int MFR_BANDGAP_OT_BIT = 7;
  localparam int MFR_VENDOR_SRC_BIT = 0;
  // Summary byte positions
  localparam int SB_OFF_BIT = 6;
  localparam int SB_OV_FAULT_BIT = 5;
  localparam int SB_OC_FAULT_BIT = 4;
  localparam int SB_TEMP_BIT = 2;
  localparam int SB_CML_BIT = 1;
  localparam int SB_OTHER_BIT = 0;
  // Summary high byte positions
  localparam int SW_VOUT_BIT = 7;
  localparam int SW_IOUT_BIT = 6;
  localparam int SW_INPUT_BIT = 5;
  localparam int SW_MFR_BIT = 4;
  localparam int SW_PNG_BIT = 3;
  // Reset values and answer byte counts
  localparam logic RST_LOW_INPUT_FLAG = 1'b1;
  localparam logic RST_PNG_MASK = 1'b1;
  localparam logic RST_PGOOD_SEEN = 1'b0;
  localparam logic RST_TURNED_ON = 1'b0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
endpackage

/* File: word_crossing.sv */
`timescale 1ns/1ps
module word_crossing
(
  // Clocks and reset
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic rst_in,
  // Source side
  input wire logic [15:0] word_in,
  // Link side
  output logic [15:0] word_out,
  output logic word_valid_out
);
  logic req_reg;
  logic [15:0] hold_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;

  // Hold stays stable while a request is outstanding
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_reg <= 1'b0;
      hold_reg <= status_summary_pkg::RST_WORD;
    end
    else if (req_reg == ack_sync_reg)
    begin
      req_reg <= ~req_reg;
      hold_reg <= word_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end
    else
    begin
      ack_meta_reg <= req_seen_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      word_out <= status_summary_pkg::RST_WORD;
      word_valid_out <= 1'b0;
    end
    else
    begin
      req_meta_reg <= req_reg;
      req_sync_reg <= req_meta_reg;
      word_valid_out <= req_sync_reg != req_seen_reg;
      if (req_sync_reg != req_seen_reg)
      begin
        req_seen_reg <= req_sync_reg;
        word_out <= hold_reg;
      end
    end
  end
endmodule

/* File: status_summary.sv */
`timescale 1ns/1ps
module status_summary
(
  // Clocks and reset
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic rst_in,
  // Detailed status sources, core clock domain
  input wire logic [7:0] vout_status_in,
  input wire logic [7:0] iout_status_in,
  input wire logic [7:0] input_status_in,
  input wire logic [7:0] temp_status_in,
  input wire logic [7:0] cml_status_in,
  input wire logic [7:0] mfr_status_in,
  input wire logic converter_enabled_in,
  // Low-input flag control
  input wire logic low_input_clear_in,
  input wire logic low_input_mask_in,
  // Power-not-good alert mask write
  input wire logic png_mask_write_in,
  input wire logic png_mask_data_in,
  // Pins from outside the clock domain
  input wire logic vin_above_on_in,
  input wire logic vin_below_off_in,
  input wire logic loop_slave_in,
  // Link command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  // Link answer
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  output logic [1:0] rd_bytes_out,
  output logic cmd_nack_out,
  // Core status outputs
  output logic low_input_flag_out,
  output logic low_input_alert_out,
  output logic power_not_good_out,
  output logic png_alert_out,
  output logic png_mask_out
);
  logic above_meta_reg;
  logic above_sync_reg;
  logic below_meta_reg;
  logic below_sync_reg;
  logic slave_meta_reg;
  logic slave_sync_reg;
  logic turned_on_reg;
  logic low_input_reg;
  logic png_mask_reg;
  logic pgood_seen_reg;
  logic png_alert_reg;
  logic low_alert_reg;
  logic [7:0] vout_eff;
  logic [7:0] input_eff;
  logic [7:0] summary_byte;
  logic [7:0] summary_high;
  logic power_not_good;
  logic [15:0] link_word;

  // Pins pass two flops before use
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      above_meta_reg <= 1'b0;
      above_sync_reg <= 1'b0;
      below_meta_reg <= 1'b0;
      below_sync_reg <= 1'b0;
      slave_meta_reg <= 1'b0;
      slave_sync_reg <= 1'b0;
    end
    else
    begin
      above_meta_reg <= vin_above_on_in;
      above_sync_reg <= above_meta_reg;
      below_meta_reg <= vin_below_off_in;
      below_sync_reg <= below_meta_reg;
      slave_meta_reg <= loop_slave_in;
      slave_sync_reg <= slave_meta_reg;
    end
  end

  // First turn-on above threshold arms latching of low input
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      turned_on_reg <= status_summary_pkg::RST_TURNED_ON;
    else if (above_sync_reg)
      turned_on_reg <= 1'b1;
  end

  // Before first turn-on the flag follows the inverse of the synced above-on pin, clear ignored
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      low_input_reg <= status_summary_pkg::RST_LOW_INPUT_FLAG;
    else if (!turned_on_reg)
      low_input_reg <= !above_sync_reg;
    else if (below_sync_reg)
      low_input_reg <= 1'b1; // Set wins over clear
    else if (low_input_clear_in)
      low_input_reg <= 1'b0;
  end

  // Alert only for latched low-input events after first turn-on
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      low_alert_reg <= 1'b0;
    else
      low_alert_reg <= low_input_reg && turned_on_reg && !low_input_mask_in;
  end

  // Loop slave forces output-voltage bits low
  always_comb
  begin
    vout_eff = slave_sync_reg ? 8'h00 : vout_status_in;
    input_eff = input_status_in;
    input_eff[status_summary_pkg::INPUT_LOW_BIT] = low_input_reg;
  end

  // Live combinational summaries; no storage, so no write can clear them
  always_comb
  begin
    summary_byte = 8'h00;
    summary_byte[status_summary_pkg::SB_OFF_BIT] = !converter_enabled_in;
    summary_byte[status_summary_pkg::SB_OV_FAULT_BIT] =
      vout_eff[status_summary_pkg::VOUT_OV_FAULT_BIT];
    summary_byte[status_summary_pkg::SB_OC_FAULT_BIT] =
      iout_status_in[status_summary_pkg::IOUT_OC_FAULT_BIT];
    summary_byte[status_summary_pkg::SB_TEMP_BIT] =
      temp_status_in[status_summary_pkg::TEMP_FAULT_BIT] ||
      temp_status_in[status_summary_pkg::TEMP_WARN_BIT];
    summary_byte[status_summary_pkg::SB_CML_BIT] = |cml_status_in;
    summary_byte[status_summary_pkg::SB_OTHER_BIT] =
      vout_eff[status_summary_pkg::VOUT_UV_FAULT_BIT] ||
      iout_status_in[status_summary_pkg::IOUT_OC_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_OV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_UV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_TON_TIMEOUT_BIT] ||
      low_input_reg ||
      vout_eff[status_summary_pkg::VOUT_LIMIT_WARN_BIT] ||
      mfr_status_in[status_summary_pkg::MFR_BANDGAP_OT_BIT] ||
      mfr_status_in[status_summary_pkg::MFR_VENDOR_SRC_BIT];
  end

  // Power-not-good is unlatched and follows sources every cycle
  always_comb
  begin
    power_not_good =
      vout_eff[status_summary_pkg::VOUT_OV_FAULT_BIT] ||
      vout_eff[status_summary_pkg::VOUT_OV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_UV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_UV_FAULT_BIT] ||
      vout_eff[status_summary_pkg::VOUT_TON_TIMEOUT_BIT] ||
      temp_status_in[status_summary_pkg::TEMP_FAULT_BIT] ||
      temp_status_in[status_summary_pkg::TEMP_WARN_BIT] ||
      iout_status_in[status_summary_pkg::IOUT_OC_FAULT_BIT] ||
      iout_status_in[status_summary_pkg::IOUT_OC_WARN_BIT] ||
      low_input_reg;
  end

  always_comb
  begin
    summary_high = 8'h00;
    summary_high[status_summary_pkg::SW_VOUT_BIT] =
      vout_eff[status_summary_pkg::VOUT_OV_FAULT_BIT] ||
      vout_eff[status_summary_pkg::VOUT_OV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_UV_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_UV_FAULT_BIT] ||
      vout_eff[status_summary_pkg::VOUT_LIMIT_WARN_BIT] ||
      vout_eff[status_summary_pkg::VOUT_TON_TIMEOUT_BIT];
    summary_high[status_summary_pkg::SW_IOUT_BIT] =
      iout_status_in[status_summary_pkg::IOUT_OC_FAULT_BIT] ||
      iout_status_in[status_summary_pkg::IOUT_OC_WARN_BIT];
    summary_high[status_summary_pkg::SW_INPUT_BIT] = |input_eff;
    summary_high[status_summary_pkg::SW_MFR_BIT] =
      mfr_status_in[status_summary_pkg::MFR_BANDGAP_OT_BIT] ||
      mfr_status_in[status_summary_pkg::MFR_VENDOR_SRC_BIT];
    summary_high[status_summary_pkg::SW_PNG_BIT] = power_not_good;
  end

  // Mask defaults to masked so a never-started part keeps alert quiet
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      png_mask_reg <= status_summary_pkg::RST_PNG_MASK;
    else if (png_mask_write_in)
      png_mask_reg <= png_mask_data_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pgood_seen_reg <= status_summary_pkg::RST_PGOOD_SEEN;
    else if (!power_not_good && converter_enabled_in)
      pgood_seen_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      png_alert_reg <= 1'b0;
    else
      png_alert_reg <= power_not_good && !png_mask_reg && pgood_seen_reg;
  end

  // Word crosses to link clock by toggle handshake; a few cycles stale at most
  word_crossing crossing_inst
  (
    .clk_in(clk_in),
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .word_in({summary_high, summary_byte}),
    .word_out(link_word),
    .word_valid_out()
  );

  // Link answer; both summaries are read-only, so writes are refused
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out <= status_summary_pkg::RST_WORD;
      rd_bytes_out <= 2'h0;
      cmd_nack_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      cmd_nack_out <= 1'b0;
      if (cmd_valid_in)
      begin
        if (cmd_write_in)
          cmd_nack_out <= 1'b1;
        else if (cmd_code_in == status_summary_pkg::CMD_SUMMARY_BYTE)
        begin
          rd_valid_out <= 1'b1;
          rd_data_out <= {8'h00, link_word[7:0]};
          rd_bytes_out <= status_summary_pkg::BYTES_ONE;
        end
        else if (cmd_code_in == status_summary_pkg::CMD_SUMMARY_WORD)
        begin
          rd_valid_out <= 1'b1;
          rd_data_out <= link_word;
          rd_bytes_out <= status_summary_pkg::BYTES_TWO;
        end
        else
          cmd_nack_out <= 1'b1;
      end
    end
  end

  assign low_input_flag_out = low_input_reg;
  assign low_input_alert_out = low_alert_reg;
  assign power_not_good_out = power_not_good;
  assign png_alert_out = png_alert_reg;
  assign png_mask_out = png_mask_reg;
endmodule

/* File: status_summary_sva.sv */
`timescale 1ns/1ps
module status_summary_sva
(
  // Clocks and reset
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire logic [7:0] vout_status_in,
  input wire logic [7:0] iout_status_in,
  input wire logic [7:0] temp_status_in,
  input wire logic low_input_mask_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  // Watched outputs
  input wire logic rd_valid_out,
  input wire logic [15:0] rd_data_out,
  input wire logic [1:0] rd_bytes_out,
  input wire logic cmd_nack_out,
  input wire logic low_input_flag_out,
  input wire logic low_input_alert_out,
  input wire logic power_not_good_out,
  input wire logic png_alert_out,
  input wire logic png_mask_out
);
  logic rd_ok;
  logic calm;
  assign rd_ok = cmd_valid_in && !cmd_write_in && cmd_code_in inside {8'h78, 8'h79};
  assign calm = vout_status_in[7:4] == 4'h0 && !vout_status_in[2] &&
    temp_status_in[7:6] == 2'h0 && !iout_status_in[7] && !iout_status_in[5];
  chk_read_answer: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rd_ok |=> rd_valid_out && !cmd_nack_out) else $error("read not answered");
  chk_word_bytes: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rd_ok && cmd_code_in == 8'h79 |=> rd_bytes_out == 2'h2) else $error("word size");
  chk_byte_upper: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rd_valid_out && rd_bytes_out == 2'h1 |-> rd_data_out[15:8] == 8'h00) else $error("upper");
  chk_refuse_write: assert property (@(posedge link_clk_in) disable iff (rst_in)
    cmd_valid_in && cmd_write_in |=> cmd_nack_out && !rd_valid_out && $stable(rd_data_out))
    else $error("write not refused");
  chk_unused_zero: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rd_valid_out |-> !rd_data_out[7] && !rd_data_out[3]) else $error("unused bit set");
  chk_png_fault: assert property (@(posedge clk_in) disable iff (rst_in)
    temp_status_in[7] || iout_status_in[7] |-> power_not_good_out) else $error("png low");
  chk_png_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    calm && !low_input_flag_out |-> !power_not_good_out) else $error("png stuck");
  chk_reset_vals: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> low_input_flag_out && png_mask_out && power_not_good_out)
    else $error("reset values");
  chk_alert_masked: assert property (@(posedge clk_in) disable iff (rst_in)
    png_mask_out && $past(png_mask_out) |-> !png_alert_out) else $error("masked alert");
  chk_alert_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(png_alert_out) |-> $past(power_not_good_out) && !$past(png_mask_out))
    else $error("alert cause");
  chk_low_alert: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(low_input_alert_out) |-> $past(low_input_flag_out) && !$past(low_input_mask_in))
    else $error("low alert cause");
  cover property (@(posedge clk_in) $rose(low_input_alert_out));
  cover property (@(posedge link_clk_in) rd_valid_out && rd_bytes_out == 2'h2);
  cover property (@(posedge link_clk_in) cmd_nack_out);
  cover property (@(posedge clk_in) $rose(png_alert_out));
endmodule
bind status_summary status_summary_sva status_summary_sva_i (.clk_in, .link_clk_in, .rst_in,
  .vout_status_in, .iout_status_in, .temp_status_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in,
  .rd_valid_out, .rd_data_out, .rd_bytes_out, .cmd_nack_out, .low_input_flag_out,
  .power_not_good_out, .png_alert_out, .png_mask_out, .low_input_mask_in, .low_input_alert_out);

/* File: pmbus_host_model.sv */
`timescale 1ns/1ps
module pmbus_host_model
(
  // Link clock
  input wire logic link_clk_in,
  // Command side
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  // Answer side
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in,
  input wire logic [1:0] rd_bytes_in,
  input wire logic cmd_nack_in
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'h00;
  end
  // Alerts are masked by png_mask_reg and low_input_mask_in in the design only, never here
  task automatic xfer(input logic [7:0] c, input logic w, output logic [15:0] d,
    output logic [1:0] n, output logic nk, output logic ok);
    int k;
    @(posedge link_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= w;
    cmd_code_out <= c;
    @(posedge link_clk_in);
    cmd_valid_out <= 1'b0;
    // Released lines show junk so a stale code cannot pass
    cmd_write_out <= ~w;
    cmd_code_out <= ~c;
    ok = 1'b0;
    nk = 1'b0;
    d = 16'h0000;
    n = 2'h0;
    for (k = 0; k < 4 && !ok; k++)
    begin
      @(posedge link_clk_in);
      if (rd_valid_in || cmd_nack_in)
      begin
        ok = 1'b1;
        d = rd_data_in;
        n = rd_bytes_in;
        nk = cmd_nack_in;
      end
    end
  endtask
endmodule

/* File: status_summary_tb_top.sv */
`timescale 1ns/1ps
module status_summary_tb_top;
  logic clk_in, link_clk_in, rst_in, cmd_valid_in, cmd_write_in, converter_enabled_in;
  logic [7:0] vout_status_in, iout_status_in, input_status_in, temp_status_in;
  logic [7:0] cml_status_in, mfr_status_in, cmd_code_in;
  logic low_input_clear_in, low_input_mask_in, png_mask_write_in, png_mask_data_in;
  logic vin_above_on_in, vin_below_off_in, loop_slave_in, rd_valid_out, cmd_nack_out;
  logic [15:0] rd_data_out, last_d;
  logic [1:0] rd_bytes_out;
  logic low_input_flag_out, low_input_alert_out, power_not_good_out, png_alert_out;
  logic png_mask_out, lo_exp;
  int mismatches, checks_done;
  localparam logic [7:0] TBL [15] = '{8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h17,
    8'h15, 8'h37, 8'h36, 8'h40, 8'h57, 8'h50, 8'h27, 8'h23};
  status_summary status_summary_i (.clk_in, .link_clk_in, .rst_in, .vout_status_in,
    .iout_status_in, .input_status_in, .temp_status_in, .cml_status_in, .mfr_status_in,
    .converter_enabled_in, .low_input_clear_in, .low_input_mask_in, .png_mask_write_in,
    .png_mask_data_in, .vin_above_on_in, .vin_below_off_in, .loop_slave_in, .cmd_valid_in,
    .cmd_write_in, .cmd_code_in, .rd_valid_out, .rd_data_out, .rd_bytes_out, .cmd_nack_out,
    .low_input_flag_out, .low_input_alert_out, .power_not_good_out, .png_alert_out,
    .png_mask_out);
  pmbus_host_model pmbus_host_model_i (.link_clk_in, .cmd_valid_out(cmd_valid_in),
    .cmd_write_out(cmd_write_in), .cmd_code_out(cmd_code_in), .rd_valid_in(rd_valid_out),
    .rd_data_in(rd_data_out), .rd_bytes_in(rd_bytes_out), .cmd_nack_in(cmd_nack_out));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #3;
    forever #62.5 link_clk_in = ~link_clk_in;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  function automatic logic [15:0] exp_word();
    logic [7:0] v, i, m;
    v = loop_slave_in ? 8'h00 : vout_status_in;
    i = iout_status_in;
    m = mfr_status_in;
    return {|v[7:2], i[7] | i[5], lo_exp | (|{input_status_in[7:4], input_status_in[2:0]}),
      m[7] | m[0],
      |{v[7:4], v[2], temp_status_in[7:6], i[7], i[5], lo_exp}, 3'h0, 1'b0,
      !converter_enabled_in, v[7], i[7], 1'b0, |temp_status_in[7:6], |cml_status_in,
      |{v[6:2], i[5], lo_exp, m[7], m[0]}};
  endfunction
  task automatic rd(input logic [7:0] c);
    logic [15:0] d, e;
    logic [1:0] n;
    logic nk, ok;
    pmbus_host_model_i.xfer(c, 1'b0, d, n, nk, ok);
    e = exp_word();
    if (c == 8'h78)
      e[15:8] = 8'h00;
    cmp({13'h0, nk, n}, {14'h0, (c == 8'h79) ? 2'h2 : 2'h1}, "answer");
    cmp(d, e, "summary");
    last_d = d;
    if (!ok)
    begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic w);
    logic [15:0] d;
    logic [1:0] n;
    logic nk, ok;
    pmbus_host_model_i.xfer(c, w, d, n, nk, ok);
    cmp({15'h0, nk & ok}, 16'h0001, "nack");
    cmp(d, last_d, "kept");
  endtask
  task automatic settle();
    // Source changes need a few cycles of both clocks to cross
    repeat (20) @(posedge clk_in);
  endtask
  task automatic put(input logic [7:0] sel, input logic [7:0] val);
    @(posedge clk_in);
    case (sel[7:4])
      4'h0: vout_status_in <= val;
      4'h1: iout_status_in <= val;
      4'h2: input_status_in <= val;
      4'h3: temp_status_in <= val;
      4'h4: cml_status_in <= val;
      default: mfr_status_in <= val;
    endcase
    settle();
  endtask
  task automatic t_reset();
    rd(8'h78);
    rd(8'h79);
    cmp({15'h0, png_mask_out}, 16'h0001, "mask default");
    @(posedge clk_in);
    png_mask_write_in <= 1'b1;
    @(posedge clk_in);
    png_mask_write_in <= 1'b0;
    settle();
    cmp({14'h0, png_mask_out, png_alert_out}, 16'h0000, "alert held");
    cmp({15'h0, low_input_alert_out}, 16'h0000, "low quiet");
    $display("test reset done");
  endtask
  task automatic t_power();
    @(posedge clk_in);
    vin_above_on_in <= 1'b1;
    converter_enabled_in <= 1'b1;
    lo_exp = 1'b0;
    settle();
    rd(8'h79);
    cmp({15'h0, power_not_good_out}, 16'h0000, "power good");
    wr(8'h78, 1'b1);
    wr(8'h7A, 1'b0);
    $display("test power done");
  endtask
  task automatic t_sources();
    foreach (TBL[k])
    begin
      put(TBL[k], 8'h01 << TBL[k][2:0]);
      rd(8'h79);
      rd(8'h78);
      wr(8'h79, 1'b1);
      put(TBL[k], 8'h00);
      rd(8'h79);
    end
    $display("test sources done");
  endtask
  task automatic t_low();
    // Set and clear in one cycle: the set must win
    @(posedge clk_in);
    vin_below_off_in <= 1'b1;
    low_input_clear_in <= 1'b1;
    lo_exp = 1'b1;
    settle();
    cmp({14'h0, low_input_flag_out, low_input_alert_out}, 16'h0003, "low set");
    rd(8'h79);
    @(posedge clk_in);
    vin_below_off_in <= 1'b0;
    low_input_clear_in <= 1'b0;
    low_input_mask_in <= 1'b1;
    settle();
    cmp({14'h0, low_input_flag_out, low_input_alert_out}, 16'h0002, "low latched");
    @(posedge clk_in);
    low_input_clear_in <= 1'b1;
    @(posedge clk_in);
    low_input_clear_in <= 1'b0;
    low_input_mask_in <= 1'b0;
    lo_exp = 1'b0;
    settle();
    cmp({14'h0, low_input_flag_out, low_input_alert_out}, 16'h0000, "low cleared");
    rd(8'h79);
    $display("test low input done");
  endtask
  task automatic t_slave();
    @(posedge clk_in);
    loop_slave_in <= 1'b1;
    put(8'h30, 8'h80);
    put(8'h00, 8'h80);
    cmp({14'h0, power_not_good_out, png_alert_out}, 16'h0003, "alert");
    rd(8'h79);
    $display("test slave done");
  endtask
  initial
  begin
    rst_in = 1'b1;
    {vout_status_in, iout_status_in, input_status_in, temp_status_in} = 32'h0000_0000;
    {cml_status_in, mfr_status_in} = 16'h0000;
    {converter_enabled_in, low_input_clear_in, low_input_mask_in, png_mask_write_in} = 4'h0;
    {png_mask_data_in, vin_above_on_in, vin_below_off_in, loop_slave_in} = 4'h0;
    lo_exp = 1'b1;
    last_d = 16'h0000;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    settle();
    t_reset();
    t_power();
    t_low();
    t_sources();
    t_slave();
    close_out();
  end
endmodule
